//--- design/host_port_pkg.sv
package host_port_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int unsigned WORD_W   = 32;
  localparam int unsigned HALF_W   = 16;
  localparam int unsigned ADDR_W   = 32;

  // ----------------------------------------------------------------------
  // Access select codes and read/write polarity
  // ----------------------------------------------------------------------
  localparam logic [1:0] SEL_CONTROL  = 2'h0;
  localparam logic [1:0] SEL_ADDRESS  = 2'h1;
  localparam logic [1:0] SEL_DATA_INC = 2'h2;
  localparam logic [1:0] SEL_DATA_FIX = 2'h3;
  localparam logic       RW_WRITE     = 1'b0;
  localparam logic       RW_READ      = 1'b1;

  // ----------------------------------------------------------------------
  // Control register layout and reset values (mirrored in both halves)
  // ----------------------------------------------------------------------
  localparam int unsigned CTRL_ORDER_BIT = 0;
  localparam int unsigned CTRL_READY_BIT = 3;
  localparam logic        ORDER_RESET    = 1'b0;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [WORD_W-1:0] DATA_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned MEM_LATENCY_NS  = 300;
  localparam int unsigned MEM_LATENCY_CYC = (MEM_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  MEM_LATENCY     = 4'(MEM_LATENCY_CYC);
  localparam logic [7:0]  MEM_PATTERN     = 8'h5A;

endpackage : host_port_pkg

//--- design/host_port_if.sv
`timescale 1ns/1ps
interface host_port_if;
  logic        strobe_n;
  logic        read_write_select;
  logic [1:0]  access_select;
  logic        halfword_select;
  logic [3:0]  byte_enables;
  logic [31:0] host_wdata;
  logic [31:0] dev_rdata;
  logic        dev_rdata_oe;
  logic        host_ready_n;

  modport device (
    input  strobe_n,
    input  read_write_select,
    input  access_select,
    input  halfword_select,
    input  byte_enables,
    input  host_wdata,
    output dev_rdata,
    output dev_rdata_oe,
    output host_ready_n
  );

  modport host (
    output strobe_n,
    output read_write_select,
    output access_select,
    output halfword_select,
    output byte_enables,
    output host_wdata,
    input  dev_rdata,
    input  dev_rdata_oe,
    input  host_ready_n
  );
endinterface : host_port_if

//--- design/host_port_device.sv
`timescale 1ns/1ps
// Behaviour
// RL1 - Host programs control, then address, then data
// RL2 - Data access launches internal word transfer
// RL3 - Narrow port: low halfword cycle then high
// RL4 - Host never breaks a halfword pair
// RL5 - First halfword waits for outstanding requests
// RL6 - Second halfword always sees ready
// RL7 - Wide port: one full-word cycle per access
// RL8 - Order bit ignored in wide mode
// RL9 - Host sets order bit before address
// RL10 - Order bit picks which halfword first
// RL11 - Codes 00 control, 01 address; rw 0=write
// RL12 - Address write updates read and write pointers
// RL13 - Local CPU may also load control, address
// RL14 - Fixed read request at strobe falling edge
// RL15 - Ready held high until data loaded
// RL16 - Reads ignore byte enables, return whole word
// RL17 - Control mirrors ready status bit
// RL18 - Code 11 fixed data, 10 autoincrement data (this device never increments the address)
// RL19 - Host rewrites control/address when switching direction
// RL20 - Host samples data after ready seen low
// RL21 - Control write accepted in either halfword
module host_port_device (
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  input  wire logic          narrow_port_mode_i,
  host_port_if.device        bus,
  input  wire logic          cpu_ctrl_we_i,
  input  wire logic          cpu_order_i,
  input  wire logic          cpu_addr_we_i,
  input  wire logic [31:0]   cpu_addr_i,
  output logic               mem_req_o,
  output logic               mem_we_o,
  output logic [31:0]        mem_addr_o,
  output logic [31:0]        mem_wdata_o,
  output logic [3:0]         mem_be_o,
  input  wire logic          mem_ack_i,
  input  wire logic [31:0]   mem_rdata_i,
  output logic               word_order_bit_o,
  output logic [31:0]        read_address_o,
  output logic [31:0]        write_address_o
);

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_READY = 2'b11,
    ST_HOLD  = 2'b10
  } state_t;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0]  strobe_meta;
  logic [1:0]  strobe_sync;
  logic        rw_meta,  rw_sync;
  logic [1:0]  sel_meta, sel_sync;
  logic        half_meta, half_sync;
  logic [3:0]  be_meta,  be_sync;
  logic [31:0] wd_meta,  wd_sync;
  logic        mode_meta, mode_sync;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      strobe_meta <= 2'b11;
      strobe_sync <= 2'b11;
      {rw_meta, rw_sync}     <= 2'b00;
      {sel_meta, sel_sync}   <= 4'h0;
      {half_meta, half_sync} <= 2'b00;
      {be_meta, be_sync}     <= 8'h00;
      {wd_meta, wd_sync}     <= 64'h0000_0000_0000_0000;
      {mode_meta, mode_sync} <= 2'b00;
    end else begin
      strobe_meta <= {strobe_meta[0], bus.strobe_n};
      strobe_sync <= {strobe_sync[0], strobe_meta[1]};
      rw_meta     <= bus.read_write_select;
      rw_sync     <= rw_meta;
      sel_meta    <= bus.access_select;
      sel_sync    <= sel_meta;
      half_meta   <= bus.halfword_select;
      half_sync   <= half_meta;
      be_meta     <= bus.byte_enables;
      be_sync     <= be_meta;
      wd_meta     <= bus.host_wdata;
      wd_sync     <= wd_meta;
      mode_meta   <= narrow_port_mode_i;
      mode_sync   <= mode_meta;
    end
  end

  // strobe_sync[0] is the settled level; strobe_sync[1] is one cycle older.
  wire strobe_fall = strobe_sync[1] & ~strobe_sync[0];
  wire strobe_rise = ~strobe_sync[1] & strobe_sync[0];

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic        order_bit;
  logic [31:0] addr_reg;
  logic [31:0] data_reg;
  logic [15:0] half_hold;
  logic        read_wait;
  state_t      state;
  logic        busy;

  // RL11 RL18 access decode
  wire is_ctrl    = sel_sync == host_port_pkg::SEL_CONTROL;
  wire is_addr    = sel_sync == host_port_pkg::SEL_ADDRESS;
  wire is_data    = sel_sync[1];
  wire is_write   = rw_sync == host_port_pkg::RW_WRITE;
  // RL3 RL7 pairing: in wide mode every cycle is a whole word
  wire narrow     = mode_sync;
  wire first_half = narrow & ~half_sync;
  wire word_done  = ~narrow | half_sync;
  // RL10 RL8 order only matters on the narrow port
  wire lsb_first  = narrow & order_bit;
  wire [31:0] full_word = ~narrow ? wd_sync :
                          lsb_first ? {wd_sync[15:0], half_hold} : {half_hold, wd_sync[15:0]};
  // RL17 ready status mirrored in both halves
  wire [15:0] ctrl_half = 16'(({15'h0000, ~busy} << host_port_pkg::CTRL_READY_BIT) |
                              ({15'h0000, order_bit} << host_port_pkg::CTRL_ORDER_BIT));
  wire [31:0] ctrl_word = {ctrl_half, ctrl_half};
  wire [31:0] rd_word   = is_ctrl ? ctrl_word : is_addr ? addr_reg : data_reg;
  // RL16 whole word returned, byte enables not consulted
  // The upper half goes first unless the order bit asks for the low half first.
  wire [15:0] rd_half   = (half_sync ~^ lsb_first) ? rd_word[31:16] : rd_word[15:0];
  wire [31:0] drive_val = narrow ? {16'h0000, rd_half} : rd_word;
  // RL2 data access starts a transfer: reads on first half, writes on word end
  wire start_read  = strobe_fall & is_data & ~is_write & (first_half | ~narrow);
  wire start_write = strobe_rise & is_data & is_write & word_done;

  // ----------------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state       <= ST_IDLE;
      busy        <= 1'b0;
      read_wait   <= 1'b0;
      mem_req_o   <= 1'b0;
      mem_we_o    <= 1'b0;
      mem_be_o    <= 4'h0;
      mem_wdata_o <= host_port_pkg::DATA_RESET;
      data_reg    <= host_port_pkg::DATA_RESET;
    end else begin
      // RL5 first-half read waits for busy sequencer
      // Without this the strobe edge would be lost and the host would finish on stale data.
      if (start_read && state != ST_IDLE) begin
        read_wait <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          // RL14 fixed read requested at strobe fall
          if (start_read || read_wait) begin
            read_wait <= 1'b0;
            mem_req_o <= 1'b1;
            mem_we_o  <= 1'b0;
            mem_be_o  <= 4'hF;
            busy      <= 1'b1;
            state     <= ST_WAIT;
          end else if (start_write) begin
            mem_req_o   <= 1'b1;
            mem_we_o    <= 1'b1;
            mem_be_o    <= be_sync;
            mem_wdata_o <= full_word;
            busy        <= 1'b1;
            state       <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (mem_ack_i) begin
            mem_req_o <= 1'b0;
            // RL15 word lands in data register before ready
            if (!mem_we_o) begin
              data_reg <= mem_rdata_i;
            end
            state <= ST_READY;
          end
        end
        ST_READY: begin
          busy  <= 1'b0;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Control and address registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      order_bit    <= host_port_pkg::ORDER_RESET;
      addr_reg     <= host_port_pkg::ADDR_RESET;
      half_hold    <= 16'h0000;
    end else begin
      if (strobe_rise && is_write && first_half) begin
        half_hold <= wd_sync[15:0];
      end
      // RL21 control write taken in either half
      if (strobe_rise && is_write && is_ctrl) begin
        order_bit <= wd_sync[host_port_pkg::CTRL_ORDER_BIT];
      // RL13 local CPU may load control
      end else if (cpu_ctrl_we_i) begin
        order_bit <= cpu_order_i;
      end
      // RL12 one address feeds both pointers
      if (strobe_rise && is_write && is_addr && word_done) begin
        addr_reg <= full_word;
      // RL13 local CPU may load address
      end else if (cpu_addr_we_i) begin
        addr_reg <= cpu_addr_i;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------------
  logic ready_n;
  logic [31:0] rdata;
  logic rdata_oe;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ready_n  <= 1'b1;
      rdata    <= 32'h0000_0000;
      rdata_oe <= 1'b0;
    end else begin
      // RL5 RL6 RL15 not ready while any transfer is outstanding
      ready_n  <= busy | read_wait | start_read | start_write | (state != ST_IDLE);
      rdata    <= drive_val;
      rdata_oe <= ~strobe_sync[0] & ~is_write;
    end
  end

  assign bus.host_ready_n = ready_n;
  assign bus.dev_rdata    = rdata;
  assign bus.dev_rdata_oe = rdata_oe;
  assign mem_addr_o       = addr_reg;
  assign word_order_bit_o = order_bit;
  assign read_address_o   = addr_reg;
  assign write_address_o  = addr_reg;

endmodule : host_port_device

//--- design/host_port_host.sv
`timescale 1ns/1ps
module host_port_host (
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  input  wire logic          narrow_port_mode_i,
  host_port_if.host          bus,
  input  wire logic          cmd_valid_i,
  input  wire logic          cmd_write_i,
  input  wire logic [1:0]    cmd_select_i,
  input  wire logic [31:0]   cmd_wdata_i,
  input  wire logic          order_bit_i,
  output logic               cmd_ready_o,
  output logic               rsp_valid_o,
  output logic [31:0]        rsp_rdata_o
);

  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_SETUP = 3'b001,
    H_WAIT  = 3'b011,
    H_END   = 3'b010,
    H_GAP   = 3'b110
  } hstate_t;

  // ----------------------------------------------------------------------
  // Synchronise ready and read data from the device pins.
  // ----------------------------------------------------------------------
  logic        rdy_meta, rdy_sync;
  logic [31:0] rd_meta,  rd_sync;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdy_meta <= 1'b1;
      rdy_sync <= 1'b1;
      rd_meta  <= 32'h0000_0000;
      rd_sync  <= 32'h0000_0000;
    end else begin
      rdy_meta <= bus.host_ready_n;
      rdy_sync <= rdy_meta;
      rd_meta  <= bus.dev_rdata;
      rd_sync  <= rd_meta;
    end
  end

  hstate_t     st;
  logic        second, write, strobe_n, half;
  logic [1:0]  sel;
  logic [31:0] wdata, acc;
  logic        order;
  logic [2:0]  settle;

  // RL3 RL10 halfword to send in this cycle, order taken from the order bit
  // With the order bit set the low half leads, otherwise the high half leads.
  wire hi_now = ~(second ^ order);
  wire [31:0] out_word = narrow_port_mode_i ? {16'h0000, hi_now ? wdata[31:16] : wdata[15:0]} : wdata;

  // ----------------------------------------------------------------------
  // Bus sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st          <= H_IDLE;
      second      <= 1'b0;
      write       <= 1'b0;
      strobe_n    <= 1'b1;
      half        <= 1'b0;
      sel         <= 2'b00;
      wdata       <= 32'h0000_0000;
      acc         <= 32'h0000_0000;
      order       <= 1'b0;
      settle      <= 3'h0;
      cmd_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= 32'h0000_0000;
    end else begin
      rsp_valid_o <= 1'b0;
      case (st)
        H_IDLE: begin
          cmd_ready_o <= 1'b1;
          // RL1 RL9 RL19 the user issues control, address, then data
          if (cmd_valid_i && cmd_ready_o) begin
            cmd_ready_o <= 1'b0;
            write <= cmd_write_i;
            sel   <= cmd_select_i;
            if (cmd_write_i && cmd_select_i == host_port_pkg::SEL_CONTROL) begin
              wdata <= {cmd_wdata_i[15:0], cmd_wdata_i[15:0]};
            end else begin
              wdata <= cmd_wdata_i;
            end
            order <= narrow_port_mode_i & order_bit_i;
            second <= 1'b0;
            half  <= 1'b0;
            st    <= H_SETUP;
          end
        end
        H_SETUP: begin
          strobe_n <= 1'b0;
          // The device flags not-ready only after its own synchroniser, and ours adds two more
          // edges, so ready is not trusted until that round trip has passed.
          settle   <= 3'h6;
          st       <= H_WAIT;
        end
        H_WAIT: begin
          if (settle != 3'h0) begin
            settle <= settle - 3'h1;
          // RL20 sample data only after ready seen low
          end else if (!rdy_sync) begin
            if (narrow_port_mode_i) begin
              if (hi_now) acc[31:16] <= rd_sync[15:0];
              else acc[15:0] <= rd_sync[15:0];
            end else begin
              acc <= rd_sync;
            end
            strobe_n <= 1'b1;
            st <= H_END;
          end
        end
        H_END: begin
          settle <= 3'h4;
          st <= H_GAP;
        end
        H_GAP: begin
          if (settle != 3'h0) begin
            settle <= settle - 3'h1;
          // RL4 RL7 second half follows directly, wide mode needs none
          end else if (narrow_port_mode_i && !second) begin
            second <= 1'b1;
            half   <= 1'b1;
            st     <= H_SETUP;
          end else begin
            rsp_valid_o <= ~write;
            rsp_rdata_o <= acc;
            half <= 1'b0;
            st   <= H_IDLE;
          end
        end
        default: st <= H_IDLE;
      endcase
    end
  end

  assign bus.strobe_n          = strobe_n;
  // RL11 RL18 direction and access code
  assign bus.read_write_select = ~write;
  assign bus.access_select     = sel;
  assign bus.halfword_select   = half;
  // RL16 reads carry arbitrary byte enables
  assign bus.byte_enables      = write ? 4'hF : wdata[3:0];
  assign bus.host_wdata        = out_word;

endmodule : host_port_host

//--- testbench/host_port_chk.sv
`timescale 1ns/1ps
module host_port_chk (
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic       narrow_port_mode_i,
  input wire logic       strobe_n,
  input wire logic       read_write_select,
  input wire logic [1:0] access_select,
  input wire logic       halfword_select,
  input wire logic       dev_rdata_oe,
  input wire logic       host_ready_n
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  logic       last_half;
  logic [1:0] last_sel;

  // Starts at one so that the first narrow strobe must be a first halfword.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      last_half <= 1'b1;
      last_sel  <= 2'h0;
    end else if ($fell(strobe_n)) begin
      last_half <= halfword_select;
      last_sel  <= access_select;
    end
  end

  a_reset_idle: assert property ($fell(reset_i) |-> strobe_n && !dev_rdata_oe)
    else $error("bus not idle after reset");
  a_pair_alternate: assert property (narrow_port_mode_i && $fell(strobe_n) |-> halfword_select != last_half)
    else $error("halfword pair out of order");
  a_pair_select: assert property (narrow_port_mode_i && $fell(strobe_n) && halfword_select |-> access_select == last_sel)
    else $error("pair broken by another access");
  a_second_ready: assert property (narrow_port_mode_i && $fell(strobe_n) && halfword_select |-> ##[0:8] !host_ready_n)
    else $error("second halfword not ready");
  a_first_wait: assert property ($fell(strobe_n) && (!narrow_port_mode_i || !halfword_select) && read_write_select
    && access_select == host_port_pkg::SEL_DATA_FIX |-> ##[1:4] host_ready_n [*2])
    else $error("fixed read ready too early");
  a_end_after_ready: assert property ($rose(strobe_n) |-> !$past(host_ready_n))
    else $error("strobe ended before ready");
  a_write_quiet: assert property (!strobe_n && !read_write_select |-> !dev_rdata_oe)
    else $error("device drives data on a write");
  a_ready_bound: assert property ($fell(strobe_n) |-> ##[1:60] !host_ready_n)
    else $error("ready never returned");
  a_hold_request: assert property (!strobe_n && !$fell(strobe_n)
    |-> $stable(access_select) && $stable(read_write_select) && $stable(halfword_select))
    else $error("request changed during strobe");
endmodule : host_port_chk

//--- testbench/host_port_access_sequencer_bench.sv
`timescale 1ns/1ps
module host_port_access_sequencer_bench;
  logic        clk_i = 1'b0, reset_i = 1'b1, narrow = 1'b1;
  logic        cpu_ctrl_we = 1'b0, cpu_order = 1'b0, cpu_addr_we = 1'b0;
  logic [31:0] cpu_addr = 32'h0000_0000, mem_rdata = 32'h0000_0000;
  logic        mem_req, mem_we, mem_ack = 1'b0, word_order_bit;
  logic [31:0] mem_addr, mem_wdata, read_address, write_address, rsp_rdata;
  logic [3:0]  mem_be;
  logic        cmd_valid = 1'b0, cmd_write = 1'b0, order_bit = 1'b0, cmd_ready, rsp_valid;
  logic [1:0]  cmd_select = 2'h0;
  logic [31:0] cmd_wdata = 32'h0000_0000, addr, mem_word;
  logic [31:0] exp_rsp[$];
  logic [64:0] exp_mem[$];
  int          err_count = 0;
  int          checks = 0;

  host_port_if bus_if();
  host_port_device host_port_device_inst (.clk_i(clk_i), .reset_i(reset_i), .narrow_port_mode_i(narrow),
    .bus(bus_if), .cpu_ctrl_we_i(cpu_ctrl_we), .cpu_order_i(cpu_order), .cpu_addr_we_i(cpu_addr_we),
    .cpu_addr_i(cpu_addr), .mem_req_o(mem_req), .mem_we_o(mem_we), .mem_addr_o(mem_addr),
    .mem_wdata_o(mem_wdata), .mem_be_o(mem_be), .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata),
    .word_order_bit_o(word_order_bit), .read_address_o(read_address), .write_address_o(write_address));
  host_port_host host_port_host_inst (.clk_i(clk_i), .reset_i(reset_i), .narrow_port_mode_i(narrow),
    .bus(bus_if), .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write), .cmd_select_i(cmd_select),
    .cmd_wdata_i(cmd_wdata), .order_bit_i(order_bit), .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid),
    .rsp_rdata_o(rsp_rdata));
  host_port_chk host_port_chk_inst (.clk_i(clk_i), .reset_i(reset_i), .narrow_port_mode_i(narrow),
    .strobe_n(bus_if.strobe_n), .read_write_select(bus_if.read_write_select),
    .access_select(bus_if.access_select), .halfword_select(bus_if.halfword_select),
    .dev_rdata_oe(bus_if.dev_rdata_oe), .host_ready_n(bus_if.host_ready_n));

  always #50 clk_i = ~clk_i;

  task automatic check(input string what, input logic [64:0] seen, input logic [64:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize

  task automatic cmd(input logic wr, input logic [1:0] sel, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    cmd_valid  <= 1'b1;
    cmd_write  <= wr;
    cmd_select <= sel;
    cmd_wdata  <= wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (cmd_ready !== 1'b1 && n < 2000);
    cmd_valid <= 1'b0;
  endtask : cmd

  // The host needs a couple of edges to drop its ready after taking a command.
  task automatic idle();
    int n;
    n = 0;
    repeat (2) @(posedge clk_i);
    while (n < 2000 && !(cmd_ready === 1'b1 && exp_rsp.size() == 0 && exp_mem.size() == 0
           && mem_req === 1'b0 && mem_ack === 1'b0)) begin
      @(posedge clk_i);
      n++;
    end
  endtask : idle

  task automatic set_addr();
    addr = $urandom;
    cmd(1'b1, host_port_pkg::SEL_ADDRESS, addr);
    idle();
    check("read_address", read_address, addr);
    check("write_address", write_address, addr);
  endtask : set_addr

  task automatic data_op(input logic [1:0] sel, input logic wr);
    logic [31:0] w;
    w = $urandom;
    mem_word = w;
    exp_mem.push_back({wr, addr, wr ? w : 32'h0000_0000});
    if (!wr) exp_rsp.push_back(w);
    cmd(wr, sel, w);
    if (!wr) idle();
  endtask : data_op

  // Fixed mode runs two operations in a row; writes go back to back, so the second waits on the first.
  task automatic traffic();
    for (int i = 0; i < 2; i++) begin
      for (int d = 0; d < 2; d++) begin
        set_addr();
        data_op(i ? host_port_pkg::SEL_DATA_INC : host_port_pkg::SEL_DATA_FIX, d[0]);
        if (i == 0) data_op(host_port_pkg::SEL_DATA_FIX, d[0]);
        idle();
      end
    end
  endtask : traffic

  initial begin : memory
    logic [64:0] e;
    forever begin
      @(posedge clk_i);
      if (mem_req === 1'b1) begin
        e = (exp_mem.size() > 0) ? exp_mem.pop_front() : '1;
        check("mem_op", {mem_we, mem_addr, mem_we ? mem_wdata : 32'h0000_0000}, e);
        if (mem_we === 1'b0) check("mem_be", mem_be, 4'hf);
        repeat ($urandom_range(4)) @(posedge clk_i);
        mem_ack   <= 1'b1;
        mem_rdata <= mem_word;
        @(posedge clk_i);
        mem_ack   <= 1'b0;
        mem_rdata <= ~mem_word;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rsp_valid === 1'b1) begin
      check("rsp_rdata", rsp_rdata, (exp_rsp.size() > 0) ? exp_rsp.pop_front() : ~rsp_rdata);
    end
  end

  initial begin
    repeat (40000) @(posedge clk_i);
    err_count++;
    summarize();
  end

  initial begin
    void'($urandom(77));
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int ob = 1; ob >= 0; ob--) begin
      order_bit <= ob[0];
      cmd(1'b1, host_port_pkg::SEL_CONTROL, ob ? 32'h0001_0001 : 32'h0000_0000);
      idle();
      check("order", word_order_bit, ob[0]);
      exp_rsp.push_back(ob ? 32'h0009_0009 : 32'h0008_0008);
      cmd(1'b0, host_port_pkg::SEL_CONTROL, 32'h0000_0000);
      idle();
      traffic();
    end
    reset_i   <= 1'b1;
    narrow    <= 1'b0;
    order_bit <= 1'b1;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    exp_rsp.push_back(32'h0008_0008);
    cmd(1'b0, host_port_pkg::SEL_CONTROL, 32'h0000_0000);
    idle();
    addr = $urandom;
    cpu_ctrl_we <= 1'b1;
    cpu_order   <= 1'b1;
    cpu_addr_we <= 1'b1;
    cpu_addr    <= addr;
    @(posedge clk_i);
    cpu_ctrl_we <= 1'b0;
    cpu_addr_we <= 1'b0;
    repeat (2) @(posedge clk_i);
    check("cpu_order", word_order_bit, 1'b1);
    check("cpu_addr", write_address, addr);
    data_op(host_port_pkg::SEL_DATA_FIX, 1'b0);
    traffic();
    idle();
    summarize();
  end
endmodule : host_port_access_sequencer_bench
